// >>> logic/lsm_bus_if.sv
// Bus-transfer channel between session core and transfer engine
`timescale 1ns/1ps
`default_nettype none
interface lsm_bus_if;
  import lsm_pkg::*;
  logic        start;   // Pulse: begin a transfer
  lsm_xfer_t   kind;    // Kind of transfer
  logic [63:0] addr;    // Bus address
  lsm_speed_t  speed;   // Bus speed
  logic [31:0] wdata;   // Quadlet to write
  logic        done;    // Pulse: transfer finished
  logic [63:0] rdata;   // Fetched value
  modport core (output start, kind, addr, speed, wdata, input done, rdata);
  modport eng  (input start, kind, addr, speed, wdata, output done, rdata);
endinterface : lsm_bus_if
`default_nettype wire

// >>> logic/lsm_cfg.svh
// Constants for the login session manager
`ifndef LSM_CFG_SVH
`define LSM_CFG_SVH
// Register offsets (word index on the plain register port)
`define LSM_OFS_REQ_ADDR_LO   4'h0
`define LSM_OFS_REQ_ADDR_HI   4'h1
`define LSM_OFS_PERMIT        4'h2
`define LSM_OFS_LOGOUT        4'h3
`define LSM_OFS_STATUS        4'h4
`define LSM_OFS_HANDLE        4'h5
`define LSM_OFS_OWNER_LO      4'h6
`define LSM_OFS_OWNER_HI      4'h7
`define LSM_OFS_TGT_LIMITS    4'h8
`define LSM_OFS_NEGOTIATED    4'h9
// Field layout of the negotiated-parameter quadlet
`define LSM_NEG_I2T_LSB       24
`define LSM_NEG_T2I_LSB       16
`define LSM_NEG_ALIVE_LSB     4
`define LSM_NEG_RESUME_LSB    0
// Reset values and codes
`define LSM_OWNER_NONE        64'hFFFF_FFFF_FFFF_FFFF
`define LSM_TGT_LIMITS_RST    32'h0808_0077
`define LSM_SRC_DEVICE        2'h2
`define LSM_SBP_RES_UNAVAIL   8'h08
// Timing
`define LSM_CLK_HZ            200000000
`define LSM_TICK_MS           1
`define LSM_GRACE_EXTRA_MS    16'd1000
`endif

// >>> logic/lsm_ms_tick.sv
// Millisecond tick divider
`timescale 1ns/1ps
`default_nettype none
`include "lsm_cfg.svh"
module lsm_ms_tick #(
  parameter int CYCLES = `LSM_CLK_HZ / 1000 * `LSM_TICK_MS
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Tick out
  output logic      tick
);
  logic [31:0] cnt_reg; // Cycle counter

  // Count cycles and pulse once per millisecond
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_reg <= 32'h0;
      tick    <= 1'b0;
    end else if (cnt_reg == 32'(CYCLES - 1)) begin
      cnt_reg <= 32'h0;
      tick    <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 32'h1;
      tick    <= 1'b0;
    end
  end
endmodule : lsm_ms_tick
`default_nettype wire

// >>> logic/lsm_pkg.sv
// Types for the login session manager
package lsm_pkg;
  typedef enum logic [1:0] {LSM_S100, LSM_S200, LSM_S400} lsm_speed_t;
  typedef enum logic [2:0] {
    LSM_XF_REQ, LSM_XF_BIB, LSM_XF_REPLY, LSM_XF_REFUSE, LSM_XF_STATUS
  } lsm_xfer_t;
endpackage : lsm_pkg

// >>> logic/lsm_session_mgr.sv
// Session manager top: login, logout, watchdogs and unsolicited status
// Functional notes
// - Reuse speed of the request write.
// - Fetch host bus info block for identifier.
// - Refuse host already holding a session.
// - Single session: refuse other hosts while held.
// - Record identifier and unique session handle.
// - Write reply to reply address last.
// - Refusal writes resources-unavailable status block.
// - Reply quadlet holds minimums of request/limit.
// - Payload limits per direction, 128-byte units.
// - Device data requests sized at negotiated limit.
// - Alive codes 100ms..15s mapping.
// - Resume codes 0..300 seconds mapping.
// - Explicit logout releases ownership at once.
// - Implicit logout starts grace timer.
// - Alive timeout: implicit logout, release resources.
// - Idle timer restarts on host activity.
// - Idle expiry: status, or logout if unpermitted.
// - Unsolicited status: link state, source two.
// - Permit cleared at login and after each unsolicited status.
// - Owner identifier all ones when unowned.
// - Same owner: token/values must match stored.
`timescale 1ns/1ps
`default_nettype none
`include "lsm_cfg.svh"
module lsm_session_mgr
  import lsm_pkg::*;
#(
  parameter int TICK_CYCLES = `LSM_CLK_HZ / 1000 * `LSM_TICK_MS
) (
  // Clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        RESET,
  // Register port
  input  wire logic [3:0]  REG_ADDR,
  input  wire logic [31:0] REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic [31:0]      REG_RDATA,
  // Link events
  input  wire logic [1:0]  REQ_SPEED,
  input  wire logic        HOST_ACTIVITY,
  input  wire logic        IMPLICIT_LOGOUT,
  input  wire logic        ALIVE_START,
  // External bus request
  output logic             EXT_REQ,
  output logic [2:0]       EXT_KIND,
  output logic [63:0]      EXT_ADDR,
  output logic [1:0]       EXT_SPEED,
  output logic [31:0]      EXT_WDATA,
  // External bus answer
  input  wire logic        EXT_ACK,
  input  wire logic [63:0] EXT_RDATA,
  // Session state
  output logic             SESSION_ACTIVE,
  output logic             UNIT_RESET,
  output logic [7:0]       T2I_REQ_UNITS
);
  typedef enum {
    ST_IDLE, ST_FETCH_REQ0, ST_FETCH_REQ1, ST_FETCH_REQ2, ST_FETCH_BIB,
    ST_CHECK, ST_REPLY0, ST_REPLY1, ST_REFUSE, ST_USTAT, ST_WAIT
  } lsm_state_t;

  lsm_bus_if bus ();                    // Core-to-engine channel
  logic        tick;                    // Millisecond tick
  lsm_state_t  state_reg, ret_reg;      // Sequencer and return state
  logic [63:0] req_addr_reg;            // Request block address
  logic [31:0] addr_lo_reg;             // Staged low address word
  lsm_speed_t  speed_reg;               // Session speed
  logic [63:0] reply_addr_reg;          // Reply address from request
  logic [63:0] fifo_addr_reg;           // Status FIFO address
  logic [31:0] req_params_reg;          // Requested parameters
  logic [15:0] req_token_reg;           // Token supplied in request
  logic [63:0] req_eui_reg;             // Requester identifier
  logic [63:0] owner_reg;               // Stored owner identifier
  logic [15:0] token_reg;               // Stored owner token
  logic [31:0] neg_reg;                 // Stored negotiated quadlet
  logic [15:0] handle_reg;              // Session handle
  logic [31:0] tgt_limits_reg;          // Device maximums
  logic        active_reg;              // Session established
  logic        permit_reg;              // Unsolicited status permit
  logic        grace_on_reg;            // Grace timer running
  logic [31:0] grace_ms_reg;            // Grace elapsed ms
  logic        idle_on_reg;             // Idle timer running
  logic [31:0] idle_ms_reg;             // Idle elapsed ms
  logic        alive_on_reg;            // Alive timer running
  logic [31:0] alive_ms_reg;            // Alive elapsed ms
  logic [1:0]  spd_s1_reg, spd_s2_reg;  // Speed synchroniser
  logic [2:0]  act_s1_reg, act_s2_reg;  // Event synchronisers
  logic        act_prev_reg;            // Activity edge memory
  logic [2:0]  imp_prev_reg;            // Implicit/alive edge memory
  logic        release_now;             // Ownership release this cycle
  logic        idle_expire, alive_expire, grace_expire;
  logic [31:0] neg_next;                // Negotiated quadlet

  // Smaller of two fields
  function automatic logic [7:0] min8(input logic [7:0] a, input logic [7:0] b);
    min8 = (a < b) ? a : b;
  endfunction : min8

  // Alive code to milliseconds
  function automatic logic [31:0] alive_ms(input logic [2:0] c);
    unique case (c)
      3'h0: alive_ms = 32'd100;
      3'h1: alive_ms = 32'd200;
      3'h2: alive_ms = 32'd500;
      3'h3: alive_ms = 32'd1000;
      3'h4: alive_ms = 32'd3000;
      3'h5: alive_ms = 32'd5000;
      3'h6: alive_ms = 32'd10000;
      3'h7: alive_ms = 32'd15000;
    endcase
  endfunction : alive_ms

  // Resume code to milliseconds
  function automatic logic [31:0] resume_ms(input logic [2:0] c);
    unique case (c)
      3'h0: resume_ms = 32'd0;
      3'h1: resume_ms = 32'd5000;
      3'h2: resume_ms = 32'd10000;
      3'h3: resume_ms = 32'd15000;
      3'h4: resume_ms = 32'd30000;
      3'h5: resume_ms = 32'd60000;
      3'h6: resume_ms = 32'd120000;
      3'h7: resume_ms = 32'd300000;
    endcase
  endfunction : resume_ms

  // Millisecond tick shared by all timers
  lsm_ms_tick #(.CYCLES(TICK_CYCLES)) u_tick (
    .clk  (CORE_CLK),
    .rst  (RESET),
    .tick (tick)
  );

  // Bus transfer engine
  lsm_xfer_engine u_eng (
    .clk       (CORE_CLK),
    .rst       (RESET),
    .bus       (bus.eng),
    .ext_req   (EXT_REQ),
    .ext_kind  (EXT_KIND),
    .ext_addr  (EXT_ADDR),
    .ext_speed (EXT_SPEED),
    .ext_wdata (EXT_WDATA),
    .ext_ack   (EXT_ACK),
    .ext_rdata (EXT_RDATA)
  );

  // Negotiated quadlet: per-field minimum of request and device limit
  always_comb begin
    neg_next = {min8(req_params_reg[31:24], tgt_limits_reg[31:24]),
                min8(req_params_reg[23:16], tgt_limits_reg[23:16]),
                8'h00,
                1'b0, 3'(min8({5'h0, req_params_reg[6:4]}, {5'h0, tgt_limits_reg[6:4]})),
                1'b0, 3'(min8({5'h0, req_params_reg[2:0]}, {5'h0, tgt_limits_reg[2:0]}))};
  end

  // Timer expiries
  assign idle_expire  = idle_on_reg && tick &&
                        idle_ms_reg + 32'h1 >= alive_ms(neg_reg[6:4]);
  assign alive_expire = alive_on_reg && tick &&
                        alive_ms_reg + 32'h1 >= alive_ms(neg_reg[6:4]);
  assign grace_expire = grace_on_reg && tick && grace_ms_reg + 32'h1 >=
                        resume_ms(neg_reg[2:0]) + {16'h0, `LSM_GRACE_EXTRA_MS};
  assign release_now  = (REG_WR && REG_ADDR == `LSM_OFS_LOGOUT && REG_WDATA[0])
                        || grace_expire || alive_expire
                        || (idle_expire && !permit_reg);

  // Synchronise link inputs through two flops
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      spd_s1_reg <= 2'h0;
      spd_s2_reg <= 2'h0;
      act_s1_reg <= 3'h0;
      act_s2_reg <= 3'h0;
      act_prev_reg <= 1'b0;
      imp_prev_reg <= 3'h0;
    end else begin
      spd_s1_reg <= REQ_SPEED;
      spd_s2_reg <= spd_s1_reg;
      act_s1_reg <= {ALIVE_START, IMPLICIT_LOGOUT, HOST_ACTIVITY};
      act_s2_reg <= act_s1_reg;
      act_prev_reg <= act_s2_reg[0];
      imp_prev_reg <= act_s2_reg;
    end
  end

  // Register writes: addresses, permit and device limits
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      addr_lo_reg    <= 32'h0;
      req_addr_reg   <= 64'h0;
      tgt_limits_reg <= `LSM_TGT_LIMITS_RST;
      permit_reg     <= 1'b0;
      speed_reg      <= LSM_S100;
    end else begin
      if (REG_WR && REG_ADDR == `LSM_OFS_REQ_ADDR_LO) addr_lo_reg <= REG_WDATA;
      if (REG_WR && REG_ADDR == `LSM_OFS_REQ_ADDR_HI && state_reg == ST_IDLE) begin
        req_addr_reg <= {REG_WDATA, addr_lo_reg};
        speed_reg    <= lsm_speed_t'(spd_s2_reg);
      end
      if (REG_WR && REG_ADDR == `LSM_OFS_TGT_LIMITS) tgt_limits_reg <= REG_WDATA;
      // Clears from device; host set wins when simultaneous
      if (state_reg == ST_WAIT && bus.done &&
          (ret_reg == ST_REPLY1 || ret_reg == ST_USTAT)) permit_reg <= 1'b0;
      if (REG_WR && REG_ADDR == `LSM_OFS_PERMIT && REG_WDATA[0])
        permit_reg <= 1'b1;
    end
  end

  // Login sequencer
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      state_reg      <= ST_IDLE;
      ret_reg        <= ST_IDLE;
      bus.start      <= 1'b0;
      bus.kind       <= LSM_XF_REQ;
      bus.addr       <= 64'h0;
      bus.speed      <= LSM_S100;
      bus.wdata      <= 32'h0;
      reply_addr_reg <= 64'h0;
      fifo_addr_reg  <= 64'h0;
      req_params_reg <= 32'h0;
      req_token_reg  <= 16'h0;
      req_eui_reg    <= 64'h0;
      owner_reg      <= `LSM_OWNER_NONE;
      token_reg      <= 16'h0;
      neg_reg        <= 32'h0;
      handle_reg     <= 16'h0;
      active_reg     <= 1'b0;
      UNIT_RESET     <= 1'b0;
    end else begin
      bus.start  <= 1'b0;
      UNIT_RESET <= 1'b0;
      if (release_now) begin
        owner_reg  <= `LSM_OWNER_NONE;
        active_reg <= 1'b0;
      end
      if (imp_prev_reg[1] == 1'b0 && act_s2_reg[1] && active_reg)
        active_reg <= 1'b0;
      unique case (state_reg)
        ST_IDLE: begin
          if (REG_WR && REG_ADDR == `LSM_OFS_REQ_ADDR_HI) begin
            bus.start <= 1'b1;
            bus.kind  <= LSM_XF_REQ;
            bus.addr  <= {REG_WDATA, addr_lo_reg};
            bus.speed <= lsm_speed_t'(spd_s2_reg);
            state_reg <= ST_WAIT;
            ret_reg   <= ST_FETCH_REQ0;
          end else if (idle_expire && permit_reg && active_reg) begin
            bus.start <= 1'b1;
            bus.kind  <= LSM_XF_STATUS;
            bus.addr  <= fifo_addr_reg;
            bus.speed <= speed_reg;
            bus.wdata <= {2'h0, `LSM_SRC_DEVICE, 28'h0};
            state_reg <= ST_WAIT;
            ret_reg   <= ST_USTAT;
          end
        end
        ST_WAIT: if (bus.done) state_reg <= ret_reg;
        ST_FETCH_REQ0: begin
          // First fetch: reply address; next fetch FIFO address
          reply_addr_reg <= bus.rdata;
          bus.start <= 1'b1;
          bus.kind  <= LSM_XF_REQ;
          bus.addr  <= req_addr_reg + 64'h8;
          state_reg <= ST_WAIT;
          ret_reg   <= ST_FETCH_REQ1;
        end
        ST_FETCH_REQ1: begin
          fifo_addr_reg <= bus.rdata;
          bus.start <= 1'b1;
          bus.addr  <= req_addr_reg + 64'h10;
          state_reg <= ST_WAIT;
          ret_reg   <= ST_FETCH_REQ2;
        end
        ST_FETCH_REQ2: begin
          // Parameters and supplied token
          req_params_reg <= bus.rdata[31:0];
          req_token_reg  <= bus.rdata[47:32];
          bus.start <= 1'b1;
          bus.kind  <= LSM_XF_BIB;
          state_reg <= ST_WAIT;
          ret_reg   <= ST_FETCH_BIB;
        end
        ST_FETCH_BIB: begin
          req_eui_reg <= bus.rdata;
          state_reg   <= ST_CHECK;
        end
        ST_CHECK: begin
          bus.start <= 1'b1;
          bus.speed <= speed_reg;
          state_reg <= ST_WAIT;
          if ((active_reg && owner_reg == req_eui_reg) ||
              (active_reg && owner_reg != req_eui_reg) ||
              (owner_reg == req_eui_reg &&
               (req_token_reg != token_reg || neg_next != neg_reg))) begin
            bus.kind  <= LSM_XF_REFUSE;
            bus.addr  <= fifo_addr_reg;
            bus.wdata <= {24'h0, `LSM_SBP_RES_UNAVAIL};
            ret_reg   <= ST_REFUSE;
          end else begin
            UNIT_RESET <= (owner_reg != req_eui_reg);
            owner_reg  <= req_eui_reg;
            handle_reg <= handle_reg + 16'h1;
            token_reg  <= handle_reg + 16'h1;
            neg_reg    <= neg_next;
            bus.kind   <= LSM_XF_REPLY;
            bus.addr   <= reply_addr_reg;
            bus.wdata  <= {handle_reg + 16'h1, 16'h0};
            ret_reg    <= ST_REPLY0;
          end
        end
        ST_REPLY0: begin
          // Extra quadlet of negotiated values
          bus.start <= 1'b1;
          bus.addr  <= reply_addr_reg + 64'h4;
          bus.wdata <= neg_reg;
          state_reg <= ST_WAIT;
          ret_reg   <= ST_REPLY1;
        end
        ST_REPLY1: begin
          active_reg <= 1'b1;
          state_reg  <= ST_IDLE;
        end
        ST_REFUSE: state_reg <= ST_IDLE;
        ST_USTAT:  state_reg <= ST_IDLE;
      endcase
    end
  end

  // Idle and alive watchdogs
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      idle_on_reg  <= 1'b0;
      idle_ms_reg  <= 32'h0;
      alive_on_reg <= 1'b0;
      alive_ms_reg <= 32'h0;
    end else begin
      if (state_reg == ST_REPLY1 || (act_s2_reg[0] && !act_prev_reg) || idle_expire) begin
        idle_on_reg <= (state_reg == ST_REPLY1) || idle_on_reg;
        idle_ms_reg <= 32'h0;
      end else if (idle_on_reg && tick) idle_ms_reg <= idle_ms_reg + 32'h1;
      if (release_now || !active_reg && state_reg != ST_REPLY1) idle_on_reg <= 1'b0;
      if (act_s2_reg[2] && !imp_prev_reg[2] && active_reg) begin
        alive_on_reg <= 1'b1;
        alive_ms_reg <= 32'h0;
      end else if (REG_WR && REG_ADDR == `LSM_OFS_PERMIT && REG_WDATA[0] || release_now)
        alive_on_reg <= 1'b0;
      else if (alive_on_reg && tick) alive_ms_reg <= alive_ms_reg + 32'h1;
    end
  end

  // Grace timer after implicit logout
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      grace_on_reg <= 1'b0;
      grace_ms_reg <= 32'h0;
    end else if (imp_prev_reg[1] == 1'b0 && act_s2_reg[1] && active_reg) begin
      grace_on_reg <= 1'b1;
      grace_ms_reg <= 32'h0;
    end else if (grace_expire || state_reg == ST_REPLY1) begin
      grace_on_reg <= 1'b0;
    end else if (grace_on_reg && tick) grace_ms_reg <= grace_ms_reg + 32'h1;
  end

  // Read port and status outputs
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      REG_RDATA      <= 32'h0;
      SESSION_ACTIVE <= 1'b0;
      T2I_REQ_UNITS  <= 8'h0;
    end else begin
      SESSION_ACTIVE <= active_reg;
      T2I_REQ_UNITS  <= neg_reg[`LSM_NEG_T2I_LSB +: 8];
      REG_RDATA      <= 32'h0;
      if (REG_RD) begin
        unique case (REG_ADDR)
          `LSM_OFS_REQ_ADDR_LO: REG_RDATA <= req_addr_reg[31:0];
          `LSM_OFS_REQ_ADDR_HI: REG_RDATA <= req_addr_reg[63:32];
          `LSM_OFS_PERMIT:      REG_RDATA <= {31'h0, permit_reg};
          `LSM_OFS_STATUS:      REG_RDATA <= {28'h0, grace_on_reg, alive_on_reg,
                                              idle_on_reg, active_reg};
          `LSM_OFS_HANDLE:      REG_RDATA <= {16'h0, handle_reg};
          `LSM_OFS_OWNER_LO:    REG_RDATA <= owner_reg[31:0];
          `LSM_OFS_OWNER_HI:    REG_RDATA <= owner_reg[63:32];
          `LSM_OFS_TGT_LIMITS:  REG_RDATA <= tgt_limits_reg;
          `LSM_OFS_NEGOTIATED:  REG_RDATA <= neg_reg;
          default:              REG_RDATA <= 32'h0;
        endcase
      end
    end
  end
endmodule : lsm_session_mgr
`default_nettype wire

// >>> logic/lsm_xfer_engine.sv
// Transfer engine: turns core requests into external bus transactions
`timescale 1ns/1ps
`default_nettype none
`include "lsm_cfg.svh"
module lsm_xfer_engine
  import lsm_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Core side
  lsm_bus_if.eng           bus,
  // External bus request
  output logic             ext_req,
  output logic [2:0]       ext_kind,
  output logic [63:0]      ext_addr,
  output logic [1:0]       ext_speed,
  output logic [31:0]      ext_wdata,
  // External bus answer
  input  wire logic        ext_ack,
  input  wire logic [63:0] ext_rdata
);
  logic busy_reg; // Transfer outstanding

  // Launch a transfer and hold the request until acknowledged
  always_ff @(posedge clk) begin
    if (rst) begin
      busy_reg  <= 1'b0;
      ext_req   <= 1'b0;
      ext_kind  <= 3'h0;
      ext_addr  <= 64'h0;
      ext_speed <= 2'h0;
      ext_wdata <= 32'h0;
      bus.done  <= 1'b0;
      bus.rdata <= 64'h0;
    end else begin
      bus.done <= 1'b0;
      if (!busy_reg && bus.start) begin
        busy_reg  <= 1'b1;
        ext_req   <= 1'b1;
        ext_kind  <= bus.kind;
        ext_addr  <= bus.addr;
        ext_speed <= bus.speed;
        ext_wdata <= bus.wdata;
      end else if (busy_reg && ext_ack) begin
        busy_reg  <= 1'b0;
        ext_req   <= 1'b0;
        bus.done  <= 1'b1;
        bus.rdata <= ext_rdata;
      end
    end
  end
endmodule : lsm_xfer_engine
`default_nettype wire

// >>> tb/lsm_host_model.sv
// Host initiator model: answers fetches and accepts writes
`timescale 1ns/1ps
`default_nettype none
module lsm_host_model #(
  parameter logic [63:0] REPLY_A = 64'h2000,      // Reply address in the request block
  parameter logic [63:0] FIFO_A  = 64'h3000,      // Status FIFO address
  parameter logic [63:0] PARAMS  = 64'h0410_0023, // Zero token and requested limits
  parameter logic [63:0] HOST_ID = 64'h0123_4567_89AB_CDEF // Arbitrary identifier
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Transfer request
  input  wire logic        req,
  input  wire logic [2:0]  kind,
  input  wire logic [63:0] addr,
  input  wire logic [3:0]  lat,
  // Answer
  output logic             ack,
  output logic [63:0]      rdata
);
  logic [3:0] cnt; // Wait cycles so far
  // Answer after lat cycles; data bus toggles when not answering
  always_ff @(posedge clk) begin
    ack   <= 1'b0;
    rdata <= ~rdata;
    if (rst) begin
      cnt   <= 4'h0;
      rdata <= 64'h0;
    end else if (req && !ack) begin
      cnt <= cnt + 4'h1;
      if (cnt >= lat) begin
        ack   <= 1'b1;
        cnt   <= 4'h0;
        // Block offsets 0, 8, 16, then identity for the info fetch
        rdata <= (kind == 3'h1) ? HOST_ID : (addr[4:3] == 2'h0) ? REPLY_A :
                 (addr[4:3] == 2'h1) ? FIFO_A : PARAMS;
      end
    end
  end
endmodule : lsm_host_model
`default_nettype wire

// >>> tb/lsm_session_mgr_chk.sv
// Port checks for the session manager
`timescale 1ns/1ps
`default_nettype none
module lsm_session_mgr_chk (
  // Clock and reset
  input wire logic        CORE_CLK,
  input wire logic        RESET,
  // Register port
  input wire logic [3:0]  REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic        REG_WR,
  input wire logic        REG_RD,
  input wire logic [31:0] REG_RDATA,
  // External bus
  input wire logic        EXT_REQ,
  input wire logic [2:0]  EXT_KIND,
  input wire logic [63:0] EXT_ADDR,
  input wire logic [1:0]  EXT_SPEED,
  input wire logic [31:0] EXT_WDATA,
  input wire logic        EXT_ACK,
  // Session state
  input wire logic        SESSION_ACTIVE,
  input wire logic        UNIT_RESET
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RESET);
  // Explicit logout of a live session
  sequence s_logout;
    REG_WR && REG_ADDR == 4'h3 && REG_WDATA[0] && SESSION_ACTIVE;
  endsequence
  // Transfer still waiting for its answer
  sequence s_wait;
    EXT_REQ && !EXT_ACK;
  endsequence
  a_req_hold: assert property (s_wait |=> EXT_REQ && $stable(EXT_ADDR) && $stable(EXT_WDATA))
    else $error("request changed before ack");
  a_ack_drop: assert property (EXT_REQ && EXT_ACK |=> !EXT_REQ)
    else $error("request held after ack");
  a_rdata_idle: assert property (!$past(REG_RD) |-> REG_RDATA == 32'h0)
    else $error("read data outside read slot");
  a_refuse_code: assert property (EXT_REQ && EXT_KIND == 3'h3 |-> EXT_WDATA == 32'h8)
    else $error("refusal status code wrong");
  a_status_src: assert property (EXT_REQ && EXT_KIND == 3'h4 |-> EXT_WDATA[29:28] == 2'h2)
    else $error("unsolicited source field wrong");
  a_speed_legal: assert property (EXT_REQ |-> EXT_SPEED <= 2'h2)
    else $error("illegal bus speed");
  a_one_session: assert property (SESSION_ACTIVE && EXT_REQ |-> EXT_KIND != 3'h2)
    else $error("reply written while session held");
  a_unit_pulse: assert property (UNIT_RESET |=> !UNIT_RESET)
    else $error("unit reset longer than one cycle");
  a_logout_now: assert property (s_logout |-> ##[1:2] !SESSION_ACTIVE)
    else $error("logout did not end session");
endmodule : lsm_session_mgr_chk
bind lsm_session_mgr lsm_session_mgr_chk u_chk (.CORE_CLK(CORE_CLK), .RESET(RESET),
  .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
  .REG_RDATA(REG_RDATA), .EXT_REQ(EXT_REQ), .EXT_KIND(EXT_KIND), .EXT_ADDR(EXT_ADDR),
  .EXT_SPEED(EXT_SPEED), .EXT_WDATA(EXT_WDATA), .EXT_ACK(EXT_ACK),
  .SESSION_ACTIVE(SESSION_ACTIVE), .UNIT_RESET(UNIT_RESET));
`default_nettype wire

// >>> tb/test_lsm_session_mgr.sv
// Testbench for the session manager
`timescale 1ns/1ps
`default_nettype none
module test_lsm_session_mgr;
  logic         clk, rst, wr, rd, act, ilo, ast, ack, req, sact, ures;
  logic [3:0]   addr, lat;
  logic [31:0]  wdata, rdata, ew;
  logic [1:0]   spd, es;
  logic [2:0]   ek;
  logic [63:0]  ea, erd;
  logic [7:0]   t2i;
  int           bad_count, checks_done, ur;
  logic [100:0] lg[$]; // Finished transfers {speed, kind, addr, wdata}
  localparam logic [2:0] KT [6] = '{3'h0, 3'h0, 3'h0, 3'h1, 3'h2, 3'h2}; // Login order
  always #2.5 clk = ~clk;
  lsm_session_mgr #(.TICK_CYCLES(10)) uut (.CORE_CLK(clk), .RESET(rst), .REG_ADDR(addr),
    .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .REQ_SPEED(spd),
    .HOST_ACTIVITY(act), .IMPLICIT_LOGOUT(ilo), .ALIVE_START(ast), .EXT_REQ(req),
    .EXT_KIND(ek), .EXT_ADDR(ea), .EXT_SPEED(es), .EXT_WDATA(ew), .EXT_ACK(ack),
    .EXT_RDATA(erd), .SESSION_ACTIVE(sact), .UNIT_RESET(ures), .T2I_REQ_UNITS(t2i));
  lsm_host_model host (.clk(clk), .rst(rst), .req(req), .kind(ek), .addr(ea), .lat(lat),
    .ack(ack), .rdata(erd));
  // Log each transfer at its answering edge
  always @(posedge clk) if (req && ack) lg.push_back({es, ek, ea, ew});
  // Count unit reset pulses
  always @(posedge clk) if (ures === 1'b1) ur++;
  task chk(input logic [98:0] g, input logic [98:0] e);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  task end_sim;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_sim
  task wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk) {addr, wdata, wr} <= {a, d, 1'b1};
    @(posedge clk) wr <= 1'b0;
  endtask : wreg
  task rreg(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk) {addr, rd} <= {a, 1'b1};
    @(posedge clk) rd <= 1'b0;
    #1 chk(rdata, e);
  endtask : rreg
  task wt(input int n);
    for (int i = 0; i < 20000 && lg.size() < n; i++) @(posedge clk);
    if (lg.size() < n) begin
      bad_count++;
      end_sim();
    end
  endtask : wt
  task login(input logic [1:0] s, input int n);
    spd <= s;
    repeat (3) @(posedge clk);
    wreg(4'h0, 32'h1000);
    wreg(4'h1, 32'h0);
    wt(n);
  endtask : login
  task login_ok(input logic [1:0] s, input int n);
    login(s, n);
    for (int i = 0; i < 6; i++) chk(lg[n - 6 + i][100:96], {s, KT[i]});
    chk(lg[n - 1][95:0], {64'h2004, 32'h0408_0023});
    repeat (4) @(posedge clk);
    chk(sact, 1'b1);
  endtask : login_ok
  initial begin
    {clk, rst, wr, rd, act, ilo, ast, addr, wdata, spd, lat} = {1'b0, 1'b1, 5'h0, 36'h0, 2'h1, 4'h0};
    {bad_count, checks_done} = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rreg(4'h6, 32'hFFFF_FFFF);
    rreg(4'h8, 32'h0808_0077);
    rreg(4'hF, 32'h0);
    $display("test reset done");
    login_ok(2'h1, 6);
    chk(t2i, 8'h08);
    rreg(4'h9, 32'h0408_0023);
    lat <= 4'h3;
    login(2'h1, 11);
    chk(lg[10][98:0], {3'h3, 64'h3000, 32'h8});
    $display("test login done");
    wreg(4'h3, 32'h1);
    repeat (3) @(posedge clk);
    chk(sact, 1'b0);
    rreg(4'h7, 32'hFFFF_FFFF);
    $display("test logout done");
    login_ok(2'h2, 17);
    act <= 1'b1;
    wreg(4'h2, 32'h1);
    wt(18);
    chk(lg[17][98:96], 3'h4);
    chk({lg[17][29:28], lg[17][95:32]}, {2'h2, 64'h3000});
    rreg(4'h2, 32'h0);
    ast <= 1'b1;
    repeat (3) @(posedge clk);
    rreg(4'h4, 32'h7);
    for (int i = 0; i < 20000 && sact; i++) @(posedge clk);
    chk(sact, 1'b0);
    $display("test idle done");
    login_ok(2'h0, 24);
    ilo <= 1'b1;
    repeat (4) @(posedge clk);
    rreg(4'h4, 32'h8);
    login(2'h0, 29);
    chk(lg[28][98:0], {3'h3, 64'h3000, 32'h8});
    chk(ur, 3);
    $display("test resume done");
    end_sim();
  end
endmodule : test_lsm_session_mgr
`default_nettype wire
